// file: dv/lcdpc_ctrl_bench.sv
// Self-checking bench for the panel controller over APB with a memory-side model.
// Assumes the 200 MHz pclk and the register map of lcdpc_map.vh.
`timescale 1ns/1ps
`include "lcdpc_map.vh"
module lcdpc_ctrl_bench;
    logic pclk, presetn, psel, penable, pwrite, test_mode, stall, pslverr, pready;
    logic [12:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, d;
    logic er, fill_done, fill_request, fsp, lop, sclk, alt, mono, bus8, irq;
    logic [3:0] pbits;
    logic [31:0] regs [8];
    logic [31:0] masks [8];
    int mismatches, checks_done, i, hi, lo, c;
    lcdpc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .test_mode(test_mode), .fill_done(fill_done),
        .fill_request(fill_request), .frame_start_pulse(fsp), .line_output_pulse(lop),
        .shift_clock(sclk), .alternation(alt), .pixel_bits(pbits), .panel_is_mono(mono),
        .panel_bus_width(bus8), .irq(irq));
    lcdpc_mem_model mem_u (.pclk(pclk), .presetn(presetn), .fill_request(fill_request),
        .stall(stall), .fill_done(fill_done));
    always #2.5 pclk = ~pclk;
    function automatic logic [12:0] ba(input logic [31:0] idx);
        ba = {idx[10:0], 2'b00};
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic sig(input int s);
        sig = (s == 0) ? sclk : (s == 1) ? !sclk : (s == 2) ? alt : fsp;
    endfunction
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            mismatches++;
            complete_run;
        end
    endtask
    // Waits for a rising level of the chosen signal and counts its high cycles.
    task automatic meas(input int s, output int h);
        int n;
        n = 0;
        h = 0;
        while (sig(s) !== 1'b0 && n < 60000) begin @(posedge pclk); n++; end
        while (sig(s) !== 1'b1 && n < 60000) begin @(posedge pclk); n++; end
        while (sig(s) === 1'b1 && n < 60000) begin @(posedge pclk); n++; h++; end
        if (n >= 60000) begin
            mismatches++;
            complete_run;
        end
    endtask
    task automatic cnt_high(output int k);
        k = 0;
        repeat (160) begin @(posedge pclk); if (lop === 1'b1) k++; end
    endtask
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        test_mode = 0; stall = 0; mismatches = 0; checks_done = 0; seed = 32'hd2378ba8;
        regs = '{`LCDPC_IDX_FRAME_END, `LCDPC_IDX_CONTROL, `LCDPC_IDX_INT_REQUEST,
            `LCDPC_IDX_CONFIG, `LCDPC_IDX_SCLK_TIMING, `LCDPC_IDX_INT_STATUS,
            `LCDPC_IDX_INT_CLEAR, `LCDPC_IDX_INT_ENABLE};
        masks = '{32'h01ff, 32'h00ef, 0, 32'hffbf, 32'h3f3f, 0, 0, 32'h0003};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 8; i++) begin apb(0, ba(regs[i]), 0); chk("reset", rd, 0); end
        // Configuration goes before control so that the stopped prescaler keeps the panel idle.
        for (i = 7; i >= 0; i--) apb(1, ba(regs[i]), 32'hffff);
        for (i = 0; i < 8; i++) begin apb(0, ba(regs[i]), 0); chk("mask", rd, masks[i]); end
        apb(0, 13'h0000, 0);
        chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        chk("irq idle", irq, 0);
        $display("registers test done");
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            d = (seed & 32'hff43) | 32'h0030 | (i << 2);
            apb(1, ba(`LCDPC_IDX_CONFIG), d);
            repeat (3) @(posedge pclk);
            chk("depth", pbits, 4'h1 << i);
            chk("mono", mono, d[1]);
            chk("bus", bus8, d[0]);
            apb(0, ba(`LCDPC_IDX_CONFIG), 0);
            chk("config", rd, d & 32'hffbf);
        end
        apb(1, ba(`LCDPC_IDX_SCLK_TIMING), 32'h0302);
        apb(1, ba(`LCDPC_IDX_CONTROL), 32'h69);
        for (i = 0; i < 3; i++) begin
            apb(1, ba(`LCDPC_IDX_CONFIG), 32'h0200 | (i << 4));
            repeat (40) @(posedge pclk);
            meas(0, hi);
            meas(1, lo);
            chk("sclk high", hi, 2 << i);
            chk("sclk low", lo, 3 << i);
        end
        apb(1, ba(`LCDPC_IDX_CONFIG), 32'h0200);
        apb(1, ba(`LCDPC_IDX_CONTROL), 32'h68);
        repeat (40) @(posedge pclk);
        meas(0, hi);
        chk("sclk negative", hi, 3);
        apb(1, ba(`LCDPC_IDX_CONTROL), 32'h60);
        repeat (4) @(posedge pclk);
        c = 0;
        lo = sclk;
        repeat (50) begin @(posedge pclk); if (sclk !== lo) c++; end
        chk("gated", c, 0);
        $display("shift clock test done");
        apb(1, ba(`LCDPC_IDX_SCLK_TIMING), 0);
        apb(1, ba(`LCDPC_IDX_FRAME_END), 2);
        for (i = 0; i < 2; i++) begin
            apb(1, ba(`LCDPC_IDX_CONTROL), 32'h68 | (i << 2));
            repeat (4) @(posedge pclk);
            cnt_high(c);
            chk("line pulse", c, i ? 159 : 1);
        end
        apb(1, ba(`LCDPC_IDX_CONTROL), 32'h68);
        meas(2, hi);
        chk("alternation", (hi + 80) / 160, 2);
        meas(3, hi);
        chk("frame pulse", (hi + 80) / 160, 2);
        apb(1, ba(`LCDPC_IDX_CONTROL), 32'h6a);
        repeat (3) @(posedge pclk);
        chk("frame polarity", fsp, 1);
        c = 0;
        for (i = 0; i < 500 && c == 0; i++) begin
            repeat (100) @(posedge pclk);
            apb(0, ba(`LCDPC_IDX_INT_REQUEST), 0);
            c = rd[2];
        end
        chk("retrace", c, 1);
        apb(0, ba(`LCDPC_IDX_INT_STATUS), 0);
        chk("vblank status", rd[1], 1);
        chk("irq on", irq, 1);
        apb(1, ba(`LCDPC_IDX_INT_CLEAR), 2);
        repeat (3) @(posedge pclk);
        chk("irq clear", irq, 0);
        $display("frame test done");
        stall <= 1'b1;
        repeat (2000) @(posedge pclk);
        apb(0, ba(`LCDPC_IDX_INT_REQUEST), 0);
        chk("overrun", rd[1], 1);
        apb(1, ba(`LCDPC_IDX_INT_ENABLE), 0);
        repeat (3) @(posedge pclk);
        chk("irq masked", irq, 0);
        apb(1, ba(`LCDPC_IDX_INT_ENABLE), 1);
        repeat (3) @(posedge pclk);
        chk("irq overrun", irq, 1);
        stall <= 1'b0;
        repeat (400) @(posedge pclk);
        apb(1, ba(`LCDPC_IDX_INT_REQUEST), 2);
        apb(0, ba(`LCDPC_IDX_INT_REQUEST), 0);
        chk("overrun kept", rd[1], 1);
        apb(1, ba(`LCDPC_IDX_INT_REQUEST), 0);
        apb(0, ba(`LCDPC_IDX_INT_REQUEST), 0);
        chk("overrun cleared", rd[1], 0);
        $display("overrun test done");
        apb(1, ba(`LCDPC_IDX_CONFIG), 32'h0280);
        cnt_high(c);
        chk("no test mode", c, 1);
        test_mode <= 1'b1;
        repeat (6) @(posedge pclk);
        cnt_high(c);
        chk("soft reset", c, 0);
        $display("soft reset test done");
        complete_run;
    end
endmodule
bind lcdpc_ctrl lcdpc_ctrl_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .test_mode(test_mode), .fill_done(fill_done),
    .fill_request(fill_request),
    .shift_clock(shift_clock), .pixel_bits(pixel_bits), .panel_is_mono(panel_is_mono),
    .panel_bus_width(panel_bus_width), .irq(irq));

// file: dv/lcdpc_ctrl_monitor.sv
// Concurrent checks on the panel controller ports.
// Bound to lcdpc_ctrl; watches only its ports, all sampled on pclk, though test_mode is an asynchronous pin.
`timescale 1ns/1ps
`include "lcdpc_map.vh"
module lcdpc_ctrl_monitor (
    input wire                     pclk,
    input wire                     presetn,
    input wire                     psel,
    input wire                     penable,
    input wire                     pwrite,
    input wire [`LCDPC_ADDR_W-1:0] paddr,
    input wire [31:0]              pwdata,
    input wire [31:0]              prdata,
    input wire                     pready,
    input wire                     pslverr,
    input wire                     test_mode,
    input wire                     fill_done,
    input wire                     fill_request,
    input wire                     shift_clock,
    input wire [3:0]               pixel_bits,
    input wire                     panel_is_mono,
    input wire                     panel_bus_width,
    input wire                     irq
);
    localparam logic [31:0] CFG_W = `LCDPC_IDX_CONFIG << 2;
    localparam logic [31:0] CTL_W = `LCDPC_IDX_CONTROL << 2;
    wire acc = psel && penable && pready && pwrite;
    wire cfg_wr = acc && (paddr == CFG_W[12:0]);
    wire ctl_wr = acc && (paddr == CTL_W[12:0]);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_error_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error response carried data");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_fill_drops: assert property (fill_request && fill_done |=> !fill_request)
        else $error("refill request stayed after done");
    // Soft reset in test mode may drop the request at any time.
    a_fill_holds: assert property (fill_request && !fill_done && !test_mode |=> fill_request)
        else $error("refill request dropped early");
    a_depth_map: assert property (cfg_wr |-> ##2 pixel_bits == (4'h1 << $past(pwdata[3:2], 2)))
        else $error("pixel depth mismatch");
    a_mono_copy: assert property (cfg_wr |-> ##2 panel_is_mono == $past(pwdata[1], 2))
        else $error("chroma select mismatch");
    a_bus_copy: assert property (cfg_wr |-> ##2 panel_bus_width == $past(pwdata[0], 2))
        else $error("bus width mismatch");
    a_gate_stops: assert property (ctl_wr && !pwdata[3] |-> ##3 $stable(shift_clock)[*8])
        else $error("shift clock ran while gated");
    c_fill: cover property (fill_request && fill_done);
    c_slverr: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
    c_cfg: cover property (cfg_wr);
endmodule

// file: dv/lcdpc_mem_model.sv
// Memory-side model answering pixel FIFO refill requests after four cycles.
// Runs on pclk; stall withholds every answer so that the FIFO starves.
`timescale 1ns/1ps
module lcdpc_mem_model (
    input  wire pclk,
    input  wire presetn,
    input  wire fill_request,
    input  wire stall,
    output reg  fill_done
);
    reg [1:0] wait_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_done <= 1'b0;
            wait_cnt  <= 2'd0;
        end else if (fill_done || !fill_request || stall) begin
            fill_done <= 1'b0;
            wait_cnt  <= 2'd0;
        end else begin
            wait_cnt  <= wait_cnt + 2'd1;
            fill_done <= (wait_cnt == 2'd3);
        end
    end
endmodule

// file: verilog/lcdpc_ctrl.v
// LCD panel controller: APB register file, clock prescaler and gate, shift clock,
// line, frame and alternation signals, pixel FIFO fill control and interrupts.
// Assumes one 200 MHz pclk domain; test_mode is an asynchronous pin, fill_done is on pclk.
`timescale 1ns/1ps
`include "lcdpc_map.vh"
module lcdpc_ctrl (
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [`LCDPC_ADDR_W-1:0] paddr,
    input  wire [31:0]              pwdata,
    output reg  [31:0]              prdata,
    output reg                      pready,
    output reg                      pslverr,
    input  wire                     test_mode,
    input  wire                     fill_done,
    output reg                      fill_request,
    output reg                      frame_start_pulse,
    output reg                      line_output_pulse,
    output reg                      shift_clock,
    output reg                      alternation,
    output reg  [3:0]               pixel_bits,
    output reg                      panel_is_mono,
    output reg                      panel_bus_width,
    output reg                      irq
);
    localparam [31:0] IDX_FEND = `LCDPC_IDX_FRAME_END;
    localparam [31:0] IDX_CTL  = `LCDPC_IDX_CONTROL;
    localparam [31:0] IDX_REQ  = `LCDPC_IDX_INT_REQUEST;
    localparam [31:0] IDX_CFG  = `LCDPC_IDX_CONFIG;
    localparam [31:0] IDX_SCT  = `LCDPC_IDX_SCLK_TIMING;
    localparam [31:0] IDX_IST  = `LCDPC_IDX_INT_STATUS;
    localparam [31:0] IDX_ICL  = `LCDPC_IDX_INT_CLEAR;
    localparam [31:0] IDX_IEN  = `LCDPC_IDX_INT_ENABLE;
    // Only the low index bits reach the bus; the upper bits are dropped on purpose.
    localparam [`LCDPC_ADDR_W-3:0] A_FEND = IDX_FEND[`LCDPC_ADDR_W-3:0];
    localparam [`LCDPC_ADDR_W-3:0] A_CTL  = IDX_CTL[`LCDPC_ADDR_W-3:0];
    localparam [`LCDPC_ADDR_W-3:0] A_REQ  = IDX_REQ[`LCDPC_ADDR_W-3:0];
    localparam [`LCDPC_ADDR_W-3:0] A_CFG  = IDX_CFG[`LCDPC_ADDR_W-3:0];
    localparam [`LCDPC_ADDR_W-3:0] A_SCT  = IDX_SCT[`LCDPC_ADDR_W-3:0];
    localparam [`LCDPC_ADDR_W-3:0] A_IST  = IDX_IST[`LCDPC_ADDR_W-3:0];
    localparam [`LCDPC_ADDR_W-3:0] A_ICL  = IDX_ICL[`LCDPC_ADDR_W-3:0];
    localparam [`LCDPC_ADDR_W-3:0] A_IEN  = IDX_IEN[`LCDPC_ADDR_W-3:0];

    reg  [8:0]  frame_pulse_end_y;
    reg  [7:0]  panel_control;
    reg         fifo_overrun_request;
    reg  [15:0] panel_config_primary;
    reg  [5:0]  shift_clk_low_cycles;
    reg  [5:0]  shift_clk_high_cycles;
    reg  [1:0]  int_status;
    reg  [1:0]  int_enable;
    reg  [2:0]  test_sync;
    reg         test_q;
    reg  [1:0]  div_cnt;
    reg         sclk_high;
    reg  [5:0]  phase_cnt;
    reg  [7:0]  sclk_in_line;
    reg  [8:0]  line_num;
    reg  [2:0]  dword_shifts;
    reg  [3:0]  fifo_level;
    reg         line_flag;
    reg         frame_flag;
    reg         alt_level;
    reg  [7:0]  alt_cnt;
    reg  [31:0] next_rdata;
    reg         next_err;
    reg         tick;

    wire [`LCDPC_ADDR_W-3:0] idx = paddr[`LCDPC_ADDR_W-1:2];
    wire        wr_en   = psel & penable & pready & pwrite;
    wire        wr_fend = wr_en & (idx == A_FEND);
    wire        wr_ctl  = wr_en & (idx == A_CTL);
    wire        wr_req  = wr_en & (idx == A_REQ);
    wire        wr_cfg  = wr_en & (idx == A_CFG);
    wire        wr_sct  = wr_en & (idx == A_SCT);
    wire        wr_icl  = wr_en & (idx == A_ICL);
    wire        wr_ien  = wr_en & (idx == A_IEN);
    wire        ctl_rst = test_q & panel_config_primary[`LCDPC_CFG_SOFTRST];
    wire [2:0]  fill_threshold = panel_control[`LCDPC_CTL_THR_LSB +: 3];
    wire [7:0]  alternation_period = panel_config_primary[`LCDPC_CFG_ALT_LSB +: 8];
    wire [1:0]  prescale = panel_config_primary[`LCDPC_CFG_PRE_LSB +: 2];
    wire [1:0]  depth    = panel_config_primary[`LCDPC_CFG_DEPTH_LSB +: 2];
    wire        vblank   = (line_num >= `LCDPC_VISIBLE_LINES);
    wire [5:0]  phase_len = sclk_high ? shift_clk_high_cycles : shift_clk_low_cycles;
    wire        phase_end = tick & (phase_cnt + 6'h01 >= phase_len);
    wire        sclk_done = phase_end & ~sclk_high;
    wire        line_end  = sclk_done & (sclk_in_line == `LCDPC_LINE_SCLKS - 8'h01);
    wire        frame_end = line_end & (line_num == `LCDPC_FRAME_LINES - 9'h001);
    wire [2:0]  dword_len = panel_config_primary[`LCDPC_CFG_BUS8] ? 3'h3 : 3'h7;
    wire        consume   = sclk_done & ~vblank & (dword_shifts == dword_len);
    wire        underrun  = consume & (fifo_level == 4'h0);
    wire        vblank_start = line_end & (line_num == `LCDPC_VISIBLE_LINES - 9'h001);

    // Controller clock tick from the prescaler, stopped while the gate bit is clear.
    always @* begin
        case (prescale)
            2'h0:    tick = panel_control[`LCDPC_CTL_GATE];
            2'h1:    tick = div_cnt[0] & panel_control[`LCDPC_CTL_GATE];
            2'h2:    tick = (div_cnt == 2'h3) & panel_control[`LCDPC_CTL_GATE];
            default: tick = 1'b0;
        endcase
    end

    // Register read mux; reserved bits stay zero.
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (idx)
            A_FEND:  next_rdata[8:0] = frame_pulse_end_y;
            A_CTL:   next_rdata[7:0] = {panel_control[7:5], 1'b0, panel_control[3:0]};
            A_REQ: begin
                next_rdata[`LCDPC_REQ_VRT] = vblank;
                next_rdata[`LCDPC_REQ_OVR] = fifo_overrun_request;
            end
            A_CFG:   next_rdata[15:0] = {panel_config_primary[15:7], 1'b0,
                                         panel_config_primary[5:0]};
            A_SCT:   next_rdata[15:0] = {2'h0, shift_clk_low_cycles,
                                         2'h0, shift_clk_high_cycles};
            A_IST:   next_rdata[1:0] = int_status;
            A_ICL:   next_rdata[1:0] = 2'h0;
            A_IEN:   next_rdata[1:0] = int_enable;
            default: next_err = 1'b1;
        endcase
    end

    // APB slave: answer is ready in the first access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & next_err;
            prdata  <= (psel & ~penable & ~pwrite) ? next_rdata : 32'h0000_0000;
        end
    end

    // Software registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_pulse_end_y     <= 9'h000;
            panel_control         <= 8'h00;
            panel_config_primary  <= `LCDPC_RST_REG16;
            shift_clk_low_cycles  <= 6'h00;
            shift_clk_high_cycles <= 6'h00;
            int_enable            <= `LCDPC_RST_INT;
        end else begin
            if (wr_fend)
                frame_pulse_end_y <= pwdata[8:0];
            if (wr_ctl)
                panel_control <= {pwdata[7:5], 1'b0, pwdata[3:0]};
            if (wr_cfg)
                panel_config_primary <= {pwdata[15:7], 1'b0, pwdata[5:0]};
            if (wr_sct) begin
                shift_clk_low_cycles  <= pwdata[`LCDPC_SCT_LOW_LSB +: 6];
                shift_clk_high_cycles <= pwdata[`LCDPC_SCT_HIGH_LSB +: 6];
            end
            if (wr_ien)
                int_enable <= pwdata[1:0];
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_overrun_request <= 1'b0;
            int_status           <= `LCDPC_RST_INT;
            irq                  <= 1'b0;
        end else begin
            if (underrun)
                fifo_overrun_request <= 1'b1;
            else if (wr_req & ~pwdata[`LCDPC_REQ_OVR])
                fifo_overrun_request <= 1'b0;
            int_status[`LCDPC_INT_OVR] <= underrun |
                (int_status[`LCDPC_INT_OVR] & ~(wr_icl & pwdata[`LCDPC_INT_OVR]));
            int_status[`LCDPC_INT_VBLANK] <= vblank_start |
                (int_status[`LCDPC_INT_VBLANK] & ~(wr_icl & pwdata[`LCDPC_INT_VBLANK]));
            irq <= |(int_status & int_enable);
        end
    end

    // Test mode pin synchroniser; a change counts once stages two and three agree.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_sync <= 3'h0;
            test_q    <= 1'b0;
        end else begin
            test_sync <= {test_sync[1:0], test_mode};
            if (test_sync[1] == test_sync[2])
                test_q <= test_sync[2];
        end
    end

    // Panel timing: shift clock phases, line and frame counters, alternation.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt      <= 2'h0;
            sclk_high    <= 1'b1;
            phase_cnt    <= 6'h00;
            sclk_in_line <= 8'h00;
            line_num     <= 9'h000;
            dword_shifts <= 3'h0;
            line_flag    <= 1'b0;
            frame_flag   <= 1'b0;
            alt_level    <= 1'b0;
            alt_cnt      <= 8'h00;
        end else if (ctl_rst) begin
            div_cnt      <= 2'h0;
            sclk_high    <= 1'b1;
            phase_cnt    <= 6'h00;
            sclk_in_line <= 8'h00;
            line_num     <= 9'h000;
            dword_shifts <= 3'h0;
            line_flag    <= 1'b0;
            frame_flag   <= 1'b0;
            alt_level    <= 1'b0;
            alt_cnt      <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 2'h1;
            if (tick)
                phase_cnt <= phase_end ? 6'h00 : phase_cnt + 6'h01;
            if (phase_end)
                sclk_high <= ~sclk_high;
            if (sclk_done) begin
                sclk_in_line <= line_end ? 8'h00 : sclk_in_line + 8'h01;
                dword_shifts <= (dword_shifts == dword_len) ? 3'h0 : dword_shifts + 3'h1;
            end
            if (tick)
                line_flag <= line_end;
            if (line_end) begin
                line_num <= frame_end ? 9'h000 : line_num + 9'h001;
                if (frame_end)
                    frame_flag <= 1'b1;
                else if (line_num + 9'h001 == frame_pulse_end_y)
                    frame_flag <= 1'b0;
                if (alternation_period == 8'h00) begin
                    if (frame_end)
                        alt_level <= ~alt_level;
                end else if (alt_cnt + 8'h01 >= alternation_period) begin
                    alt_cnt   <= 8'h00;
                    alt_level <= ~alt_level;
                end else begin
                    alt_cnt <= alt_cnt + 8'h01;
                end
            end
        end
    end

    // Pixel FIFO level and refill request.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_level   <= 4'h0;
            fill_request <= 1'b0;
        end else if (ctl_rst) begin
            fifo_level   <= 4'h0;
            fill_request <= 1'b0;
        end else begin
            if (fill_done & fill_request) begin
                fifo_level   <= `LCDPC_FIFO_DWORDS;
                fill_request <= 1'b0;
            end else begin
                if (consume & ~underrun)
                    fifo_level <= fifo_level - 4'h1;
                if (fifo_level <= {1'b0, fill_threshold})
                    fill_request <= 1'b1;
            end
        end
    end

    // Panel pins, registered, with polarity applied.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_start_pulse <= 1'b0;
            line_output_pulse <= 1'b0;
            shift_clock       <= 1'b0;
            alternation       <= 1'b0;
            pixel_bits        <= 4'h1;
            panel_is_mono     <= 1'b0;
            panel_bus_width   <= 1'b0;
        end else begin
            frame_start_pulse <= frame_flag ^ panel_control[`LCDPC_CTL_FPOL];
            line_output_pulse <= line_flag ^ panel_control[`LCDPC_CTL_LPOL];
            shift_clock       <= sclk_high ^ ~panel_control[`LCDPC_CTL_SPOL];
            alternation       <= alt_level;
            pixel_bits        <= 4'h1 << depth;
            panel_is_mono     <= panel_config_primary[`LCDPC_CFG_MONO];
            panel_bus_width   <= panel_config_primary[`LCDPC_CFG_BUS8];
        end
    end
endmodule

// file: verilog/lcdpc_map.vh
// Register indices, field positions, reset values and timing counts of the panel controller.
// Included by the controller; holds definitions only.
`ifndef LCDPC_MAP_VH
`define LCDPC_MAP_VH
// Register indices; the APB byte address is four times the low 11 bits of the index.
`define LCDPC_IDX_FRAME_END     32'h0a00040e
`define LCDPC_IDX_CONTROL       32'h0a000410
`define LCDPC_IDX_INT_REQUEST   32'h0a000412
`define LCDPC_IDX_CONFIG        32'h0a000414
`define LCDPC_IDX_SCLK_TIMING   32'h0a000416
`define LCDPC_IDX_INT_STATUS    32'h0a000430
`define LCDPC_IDX_INT_CLEAR     32'h0a000431
`define LCDPC_IDX_INT_ENABLE    32'h0a000432
`define LCDPC_ADDR_W            13
// Control register fields.
`define LCDPC_CTL_THR_LSB       5
`define LCDPC_CTL_GATE          3
`define LCDPC_CTL_LPOL          2
`define LCDPC_CTL_FPOL          1
`define LCDPC_CTL_SPOL          0
// Interrupt request register fields.
`define LCDPC_REQ_VRT           2
`define LCDPC_REQ_OVR           1
// Configuration register fields.
`define LCDPC_CFG_ALT_LSB       8
`define LCDPC_CFG_SOFTRST       7
`define LCDPC_CFG_PRE_LSB       4
`define LCDPC_CFG_DEPTH_LSB     2
`define LCDPC_CFG_MONO          1
`define LCDPC_CFG_BUS8          0
// Shift clock timing fields.
`define LCDPC_SCT_LOW_LSB       8
`define LCDPC_SCT_HIGH_LSB      0
// Interrupt status, clear and enable fields.
`define LCDPC_INT_VBLANK        1
`define LCDPC_INT_OVR           0
// Reset values.
`define LCDPC_RST_REG16         16'h0000
`define LCDPC_RST_INT           2'h0
// Timing counts.
`define LCDPC_LINE_SCLKS        8'h50
`define LCDPC_FRAME_LINES       9'h0f0
`define LCDPC_VISIBLE_LINES     9'h0e8
`define LCDPC_FIFO_DWORDS       4'h8
`define LCDPC_SYNC_STAGES       3
`endif
